// file: common/mcs_pkg.sv
// package: command and status word layouts for the modem mailbox interpreter
package mcs_pkg;
   localparam int WORD_BYTES = 3;
   // first command byte fields
   localparam int MODE_LSB     = 0;
   localparam int MODE_W       = 4;
   localparam int SIG_LSB      = 4;
   localparam int SIG_W        = 2;
   localparam int ANS_ORIG_BIT = 7;
   // receive first byte extra controls
   localparam int RX_ANS_TONE_BIT = 4;
   localparam int RX_TX_SYNC_BIT  = 5;
   localparam int RX_CD_LEVEL_BIT = 6;
   // second command byte fields
   localparam int ATTEN_LSB      = 0;
   localparam int ATTEN_W        = 5;
   localparam int RX_LEVEL_BIT   = 1;
   localparam int RX_ADDCLK_BIT  = 3;
   localparam int SCRAMBLE_BIT   = 5;
   localparam int X64_BIT        = 6;
   localparam int RATE_BIT       = 7;
   // third byte
   localparam int DIR_BIT        = 0;
   localparam int TX_DATA_LSB    = 1;
   localparam int TX_DATA_W      = 6;
   localparam int TX_ENABLE_BIT  = 7;
   // receive status layout
   localparam int ST_PRE_LSB     = 1;
   localparam int ST_PRE_W       = 4;
   localparam int ST_S1A_BIT     = 6;
   localparam int ST_S1B_BIT     = 7;
   localparam int ST_EQ_BIT      = 4;
   localparam int ST_SQ_BIT      = 5;
   localparam int ST_CD_BIT      = 6;
   localparam int ST_POST_LSB    = 1;
   localparam int ST_POST_W      = 6;
   localparam int ST_ANS_DET_BIT = 7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   typedef enum logic [3:0] {
      MCS_MODE_OFF    = 4'h0,
      MCS_MODE_V22BIS = 4'h1,
      MCS_MODE_V22    = 4'h2,
      MCS_MODE_B212   = 4'h3,
      MCS_MODE_V23    = 4'h4,
      MCS_MODE_V21    = 4'h5,
      MCS_MODE_B103   = 4'h6,
      MCS_MODE_DTMF   = 4'h7
   } mcs_mode_t;
   typedef enum logic [1:0] {
      MCS_SIG_OFF  = 2'h0,
      MCS_SIG_550  = 2'h1,
      MCS_SIG_RSVD = 2'h2,
      MCS_SIG_1800 = 2'h3
   } mcs_sig_t;
endpackage

// file: common/mcs_byte_if.sv
// interface: byte handshake between the interpreter and its status word serialiser
`timescale 1ns/1ps
interface mcs_byte_if;
   logic       load;
   logic [7:0] word0;
   logic [7:0] word1;
   logic [7:0] word2;
   logic       ready;
   logic       valid;
   logic [7:0] data;
   logic       last;
   logic       busy;
   modport src (output load, word0, word1, word2, ready, input valid, data, last, busy);
   modport ser (input load, word0, word1, word2, ready, output valid, data, last, busy);
endinterface

// file: rtl/mcs_status_ser.sv
// status word serialiser: sends three stored bytes, first byte first
`timescale 1ns/1ps
module mcs_status_ser
   import mcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   mcs_byte_if.ser  bi
);
   logic [7:0] held [WORD_BYTES];
   logic [1:0] idx;
   logic       active;

   // a load while busy is ignored so a word is never torn mid-transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active <= 1'b0;
         idx    <= 2'h0;
      end else if (!active && bi.load) begin
         active <= 1'b1;
         idx    <= 2'h0;
      end else if (active && bi.ready) begin
         if (idx == 2'(WORD_BYTES - 1)) begin
            active <= 1'b0;
            idx    <= 2'h0;
         end else begin
            idx <= idx + 2'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held[0] <= BYTE_RESET;
         held[1] <= BYTE_RESET;
         held[2] <= BYTE_RESET;
      end else if (!active && bi.load) begin
         held[0] <= bi.word0;
         held[1] <= bi.word1;
         held[2] <= bi.word2;
      end
   end

   assign bi.valid = active;
   assign bi.data  = active ? held[idx] : BYTE_RESET;
   assign bi.last  = active && (idx == 2'(WORD_BYTES - 1));
   assign bi.busy  = active;
endmodule

// file: rtl/mcs_cmd_status.sv
// modem mailbox command word decoder and receive status word builder
`timescale 1ns/1ps
// Operation
// - first transmit byte bits 0-3 pick transmit mode, 0111 is tone dialling
// - transmit signalling 00 off, 01 550Hz tone, 11 1800Hz tone
// - in tone dialling, first byte bit 7 picks high or low tone
// - in tone dialling, second byte bit 7 picks dual or single tone
// - receive byte one: mode, 0111 call progress; then tone, sync, level, direction
// - in QAM/DPSK unused data bits of receive status read as one
// - status byte one bits 6-7 report S1; call progress uses bit 7
// - status byte two: equalised bit 4, quality bit 5, carrier bit 6
// - QAM/DPSK pre-descramble data in byte one bits 1-4, post in byte three
module mcs_cmd_status
   import mcs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       cmd_restart,
   output logic            cmd_done,
   output logic            cmd_reserved_err,
   output mcs_mode_t       tx_mode,
   output mcs_sig_t        tx_signalling,
   output logic            tx_answer_originate_select,
   output logic            tx_dtmf_high_tone,
   output logic [4:0]      tx_attenuation,
   output logic            tx_scrambler_on,
   output logic            tx_x64_on,
   output logic            tx_rate_select,
   output logic            tx_dtmf_dual_tone,
   output logic [5:0]      tx_data,
   output logic            tx_enable,
   output mcs_mode_t       rx_mode,
   output logic            rx_call_progress,
   output logic            rx_answer_tone_sel,
   output logic            rx_tx_sync,
   output logic            rx_cd_level,
   output logic            rx_answer_originate_select,
   output logic            rx_line_level,
   output logic            rx_add_clocks,
   output logic            rx_descrambler_on,
   output logic            rx_x64_on,
   output logic            rx_rate_select,
   input  wire logic       st_req,
   input  wire logic [3:0] st_pre_data,
   input  wire logic [5:0] st_post_data,
   input  wire logic [2:0] st_data_width,
   input  wire logic       st_s1_det,
   input  wire logic       st_cp_tone_det,
   input  wire logic       st_eq_done,
   input  wire logic       st_quality_ok,
   input  wire logic       st_carrier_det,
   input  wire logic       st_answer_tone_det,
   input  wire logic       st_ready,
   output logic            st_valid,
   output logic [7:0]      st_byte,
   output logic            st_last,
   output logic            st_busy
);
   logic [7:0] cmd_b0;
   logic [7:0] cmd_b1;
   logic [1:0] cmd_idx;
   logic       word_done;
   logic       is_rx;
   logic       rsvd_bad;
   logic       qam;
   logic [5:0] keep_mask;
   logic [7:0] st0;
   logic [7:0] st1;
   logic [7:0] st2;

   mcs_byte_if bi ();

   // collect bytes; the third byte completes the word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_idx <= 2'h0;
         cmd_b0  <= BYTE_RESET;
         cmd_b1  <= BYTE_RESET;
      end else if (cmd_restart) begin
         cmd_idx <= 2'h0;
      end else if (cmd_valid) begin
         case (cmd_idx)
            2'h0: begin
               cmd_b0  <= cmd_byte;
               cmd_idx <= 2'h1;
            end
            2'h1: begin
               cmd_b1  <= cmd_byte;
               cmd_idx <= 2'h2;
            end
            default: begin
               cmd_idx <= 2'h0;
            end
         endcase
      end
   end

   assign word_done = cmd_valid && !cmd_restart && (cmd_idx == 2'h2);
   assign is_rx     = cmd_byte[DIR_BIT];

   // reserved bits must be zero; a violating word is flagged, still obeyed
   always_comb begin
      rsvd_bad = 1'b0;
      if (is_rx) begin
         rsvd_bad = cmd_b1[2] || (cmd_byte[7:1] != 7'h00);
      end else begin
         rsvd_bad = cmd_b0[6] || (cmd_b0[5:4] == MCS_SIG_RSVD);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_done         <= 1'b0;
         cmd_reserved_err <= 1'b0;
      end else begin
         cmd_done         <= word_done;
         cmd_reserved_err <= word_done && rsvd_bad;
      end
   end

   // transmit settings change only when the whole word is in
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_mode                    <= MCS_MODE_OFF;
         tx_signalling              <= MCS_SIG_OFF;
         tx_answer_originate_select <= 1'b0;
         tx_dtmf_high_tone          <= 1'b0;
         tx_attenuation             <= 5'h00;
         tx_scrambler_on            <= 1'b0;
         tx_x64_on                  <= 1'b0;
         tx_rate_select             <= 1'b0;
         tx_dtmf_dual_tone          <= 1'b0;
         tx_data                    <= 6'h00;
         tx_enable                  <= 1'b0;
      end else if (word_done && !is_rx) begin
         tx_mode         <= mcs_mode_t'(cmd_b0[MODE_LSB +: MODE_W]);
         tx_signalling   <= mcs_sig_t'(cmd_b0[SIG_LSB +: SIG_W]);
         tx_attenuation  <= cmd_b1[ATTEN_LSB +: ATTEN_W];
         tx_scrambler_on <= cmd_b1[SCRAMBLE_BIT];
         tx_x64_on       <= cmd_b1[X64_BIT];
         tx_data         <= cmd_byte[TX_DATA_LSB +: TX_DATA_W];
         tx_enable       <= cmd_byte[TX_ENABLE_BIT];
         if (cmd_b0[MODE_LSB +: MODE_W] == MCS_MODE_DTMF) begin
            tx_dtmf_high_tone <= cmd_b0[ANS_ORIG_BIT];
            tx_dtmf_dual_tone <= cmd_b1[RATE_BIT];
         end else begin
            tx_answer_originate_select <= cmd_b0[ANS_ORIG_BIT];
            tx_rate_select             <= cmd_b1[RATE_BIT];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_mode                    <= MCS_MODE_OFF;
         rx_answer_tone_sel         <= 1'b0;
         rx_tx_sync                 <= 1'b0;
         rx_cd_level                <= 1'b0;
         rx_answer_originate_select <= 1'b0;
         rx_line_level              <= 1'b0;
         rx_add_clocks              <= 1'b0;
         rx_descrambler_on          <= 1'b0;
         rx_x64_on                  <= 1'b0;
         rx_rate_select             <= 1'b0;
      end else if (word_done && is_rx) begin
         rx_mode                    <= mcs_mode_t'(cmd_b0[MODE_LSB +: MODE_W]);
         rx_answer_tone_sel         <= cmd_b0[RX_ANS_TONE_BIT];
         rx_tx_sync                 <= cmd_b0[RX_TX_SYNC_BIT];
         rx_cd_level                <= cmd_b0[RX_CD_LEVEL_BIT];
         rx_answer_originate_select <= cmd_b0[ANS_ORIG_BIT];
         rx_line_level              <= cmd_b1[RX_LEVEL_BIT];
         rx_add_clocks              <= cmd_b1[RX_ADDCLK_BIT];
         rx_descrambler_on          <= cmd_b1[SCRAMBLE_BIT];
         rx_x64_on                  <= cmd_b1[X64_BIT];
         rx_rate_select             <= cmd_b1[RATE_BIT];
      end
   end

   // same code as tone dialling means call progress detection on receive
   assign rx_call_progress = (rx_mode == MCS_MODE_DTMF);
   assign qam = (rx_mode == MCS_MODE_V22BIS) || (rx_mode == MCS_MODE_V22)
             || (rx_mode == MCS_MODE_B212);

   // in QAM/DPSK modes, bits at and above the live data width are unused and forced high
   always_comb begin
      keep_mask = 6'h00;
      for (int i = 0; i < ST_POST_W; i++) begin
         keep_mask[i] = (3'(i) < st_data_width);
      end
   end

   always_comb begin
      st0 = BYTE_RESET;
      st1 = BYTE_RESET;
      st2 = BYTE_RESET;
      st0[DIR_BIT] = 1'b1;
      st1[ST_EQ_BIT] = st_eq_done;
      st1[ST_SQ_BIT] = st_quality_ok;
      st1[ST_CD_BIT] = st_carrier_det;
      st2[ST_ANS_DET_BIT] = st_answer_tone_det;
      if (rx_call_progress) begin
         st0[ST_S1B_BIT] = st_cp_tone_det;
      end else begin
         st0[ST_S1A_BIT] = st_s1_det;
         st0[ST_S1B_BIT] = st_s1_det;
      end
      if (qam) begin
         st0[ST_PRE_LSB +: ST_PRE_W] = st_pre_data | ~keep_mask[3:0];
         st2[ST_POST_LSB +: ST_POST_W] = st_post_data | ~keep_mask;
      end else begin
         st2[ST_POST_LSB +: ST_POST_W] = st_post_data;
      end
   end

   assign bi.load  = st_req;
   assign bi.word0 = st0;
   assign bi.word1 = st1;
   assign bi.word2 = st2;
   assign bi.ready = st_ready;

   mcs_status_ser u_ser (
      .clk (clk),
      .rst (rst),
      .bi  (bi)
   );

   assign st_valid = bi.valid;
   assign st_byte  = bi.data;
   assign st_last  = bi.last;
   assign st_busy  = bi.busy;
endmodule

// file: verif/mcs_cmd_status_checker.sv
// checker: framing and timing properties at the interpreter ports
`timescale 1ns/1ps
module mcs_cmd_status_checker
   import mcs_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic       cmd_restart,
   input wire logic       cmd_done,
   input wire mcs_mode_t  tx_mode,
   input wire mcs_mode_t  rx_mode,
   input wire logic       rx_call_progress,
   input wire logic       st_req,
   input wire logic       st_ready,
   input wire logic       st_valid,
   input wire logic [7:0] st_byte,
   input wire logic       st_last,
   input wire logic       st_busy
);
   logic [1:0] nbyte;
   logic [1:0] sidx;
   logic       third;
   logic [3:0] first_mode;
   // restart wins over a byte in the same cycle, so it must not count that byte
   assign third = cmd_valid && !cmd_restart && nbyte == 2'h2;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         nbyte <= 2'h0;
      else if (cmd_restart || third)
         nbyte <= 2'h0;
      else if (cmd_valid)
         nbyte <= nbyte + 2'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         sidx <= 2'h0;
      else if (st_valid && st_ready)
         sidx <= st_last ? 2'h0 : sidx + 2'h1;
   end
   // mode nibble of the word being collected, so a receive word's effect is checked end to end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         first_mode <= 4'h0;
      else if (cmd_valid && !cmd_restart && nbyte == 2'h0)
         first_mode <= cmd_byte[MODE_LSB +: MODE_W];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   done_after_third_a: assert property (third |=> cmd_done)
      else $error("no done after third byte");
   done_only_third_a: assert property (cmd_done |-> $past(third))
      else $error("done without a third byte");
   call_progress_a: assert property (rx_call_progress == (rx_mode == MCS_MODE_DTMF))
      else $error("call progress flag mismatch");
   receive_mode_a: assert property (third && cmd_byte[DIR_BIT] |=>
      rx_mode == first_mode && rx_call_progress == (first_mode == MCS_MODE_DTMF))
      else $error("receive word did not set the receive mode");
   tx_hold_a: assert property (!$stable(tx_mode) |-> $past(third && !cmd_byte[DIR_BIT]))
      else $error("transmit mode moved mid word");
   status_answer_a: assert property (st_req && !st_busy |=> st_valid && sidx == 2'h0)
      else $error("status word did not start");
   status_hold_a: assert property (st_valid && !st_ready |=> st_valid && $stable(st_byte))
      else $error("status byte dropped while stalled");
   receive_flag_a: assert property (st_valid && sidx == 2'h0
      |-> st_byte[0] && !st_byte[5])
      else $error("first status byte flags wrong");
   last_byte_a: assert property (st_valid |-> st_last == (sidx == 2'h2))
      else $error("last flag on wrong byte");
   cover property (third);
   cover property (st_valid && !st_ready);
   cover property (st_valid && st_ready && st_last);
   cover property (third && cmd_byte[DIR_BIT]);
endmodule
bind mcs_cmd_status mcs_cmd_status_checker chk (.clk, .rst, .cmd_valid, .cmd_byte, .cmd_restart,
   .cmd_done, .tx_mode, .rx_mode, .rx_call_progress, .st_req, .st_ready, .st_valid,
   .st_byte, .st_last, .st_busy);

// file: verif/mcs_host_model.sv
// host model: writes command words and reads status words over the mailbox ports
`timescale 1ns/1ps
module mcs_host_model (
   input wire logic       clk,
   output logic           cmd_valid,
   output logic [7:0]     cmd_byte,
   output logic           cmd_restart,
   output logic           st_req,
   output logic           st_ready,
   input wire logic [7:0] st_byte
);
   initial
      {cmd_valid, cmd_byte, cmd_restart, st_req, st_ready} = '0;
   // bytes go first byte first with no gap; reserved bits are the caller's
   task automatic put_word(input logic [23:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cmd_valid <= 1'b1;
         cmd_byte  <= w[8*i +: 8];
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      // stale data is not left on the byte lines
      cmd_byte  <= ~cmd_byte;
   endtask
   task automatic restart;
      @(posedge clk);
      cmd_restart <= 1'b1;
      @(posedge clk);
      cmd_restart <= 1'b0;
   endtask
   // stall holds ready low that many cycles before each byte
   task automatic get_status(input int stall, output logic [23:0] s);
      @(posedge clk);
      st_req <= 1'b1;
      @(posedge clk);
      st_req <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (stall > 0) begin
            st_ready <= 1'b0;
            repeat (stall) @(posedge clk);
         end
         st_ready <= 1'b1;
         #1;
         s[8*i +: 8] = st_byte;
         @(posedge clk);
      end
      st_ready <= 1'b0;
   endtask
endmodule

// file: verif/modem_command_status_words_tb.sv
// testbench: command decode and status word checks for the mailbox interpreter
`timescale 1ns/1ps
module modem_command_status_words_tb
   import mcs_pkg::*;
;
   logic        clk, rst, cmd_valid, cmd_restart, cmd_done, cmd_reserved_err, tx_enable;
   logic [7:0]  cmd_byte, st_byte;
   mcs_mode_t   tx_mode, rx_mode;
   mcs_sig_t    tx_signalling;
   logic        tx_answer_originate_select, tx_dtmf_high_tone, tx_scrambler_on, tx_x64_on;
   logic        tx_rate_select, tx_dtmf_dual_tone, rx_call_progress, rx_answer_tone_sel;
   logic [4:0]  tx_attenuation;
   logic [5:0]  tx_data, st_post_data;
   logic        rx_tx_sync, rx_cd_level, rx_answer_originate_select, rx_line_level;
   logic        rx_add_clocks, rx_descrambler_on, rx_x64_on, rx_rate_select, st_req;
   logic        st_s1_det, st_cp_tone_det, st_eq_done, st_quality_ok, st_carrier_det;
   logic        st_answer_tone_det, st_ready, st_valid, st_last, st_busy;
   logic [3:0]  st_pre_data, md;
   logic [2:0]  st_data_width;
   logic [1:0]  sg;
   logic [18:0] stim;
   logic [23:0] s, exp;
   int          num_errors, total_checks;
   mcs_cmd_status uut (.*);
   mcs_host_model host (.clk, .cmd_valid, .cmd_byte, .cmd_restart, .st_req, .st_ready,
      .st_byte);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] want);
      total_checks++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      give_verdict;
   end
   initial begin
      rst = 1'b1;
      {st_pre_data, st_post_data, st_data_width, st_s1_det, st_cp_tone_det} = '0;
      {st_eq_done, st_quality_ok, st_carrier_det, st_answer_tone_det} = '0;
      num_errors = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({tx_mode, rx_mode, st_valid, cmd_done}, 24'h0);
      $display("reset test done");
      for (int m = 0; m < 8; m++) begin
         sg = (m % 3 == 2) ? 2'h3 : 2'(m % 3);
         host.put_word({1'b1, 6'(m * 5), 1'b0, m[1], m[2], m[0], 5'(m + 3), m[0], 1'b0, sg,
            4'(m)}, 3);
         #1;
         chk({cmd_done, cmd_reserved_err, tx_mode, tx_signalling, tx_enable, tx_data},
            {2'h2, 4'(m), sg, 1'b1, 6'(m * 5)});
         chk({tx_attenuation, tx_scrambler_on, tx_x64_on}, {5'(m + 3), m[0], m[2]});
         // tone dialling reuses bit 7 of both bytes and leaves the line settings alone
         if (m < 7)
            chk({tx_answer_originate_select, tx_rate_select}, {m[0], m[1]});
         else
            chk({tx_answer_originate_select, tx_rate_select, tx_dtmf_high_tone,
               tx_dtmf_dual_tone}, 4'b0111);
      end
      $display("transmit command test done");
      for (int m = 0; m < 8; m++) begin
         host.put_word({8'h01, m[1], m[2], m[0], 1'b0, m[1], 1'b0, m[2], 1'b0, ~m[0], m[1],
            m[2], m[0], 4'(m)}, 3);
         #1;
         chk({rx_mode, rx_call_progress, rx_answer_tone_sel, rx_tx_sync, rx_cd_level,
            rx_answer_originate_select, tx_mode}, {4'(m), m == 7, m[0], m[2], m[1], ~m[0],
            4'h7});
         chk({rx_line_level, rx_add_clocks, rx_descrambler_on, rx_x64_on, rx_rate_select},
            {m[2], m[1], m[0], m[2], m[1]});
      end
      $display("receive command test done");
      for (int k = 0; k < 2; k++) begin
         host.put_word({16'h8000, k ? 8'h21 : 8'h41}, 3);
         #1;
         chk({cmd_done, cmd_reserved_err, tx_mode}, 6'h31);
      end
      host.put_word(24'h800004, 2);
      host.restart;
      #1;
      chk({cmd_done, tx_mode}, 5'h01);
      host.put_word(24'h800005, 3);
      #1;
      chk({cmd_done, tx_mode}, 5'h15);
      $display("reserved and restart test done");
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: {md, stim, exp} = {4'h1, 4'h0, 6'h00, 3'h2, 6'b101010, 24'h7850d9};
            1: {md, stim, exp} = {4'h5, 4'h0, 6'h2b, 3'h0, 6'b000101, 24'hd62001};
            2: {md, stim, exp} = {4'h7, 4'h0, 6'h00, 3'h0, 6'b010000, 24'h000081};
            default: {md, stim, exp} = {4'h3, 4'ha, 6'h15, 3'h6, 6'b000000, 24'h2a0015};
         endcase
         host.put_word({16'h0100, 4'h0, md}, 3);
         @(posedge clk);
         {st_pre_data, st_post_data, st_data_width, st_s1_det, st_cp_tone_det, st_eq_done,
            st_quality_ok, st_carrier_det, st_answer_tone_det} <= stim;
         host.get_status(k % 3, s);
         chk(s, exp);
      end
      $display("status word test done");
      give_verdict;
   end
endmodule
